// File: design/switch_spi_command_and_diagnosis.v
// Serial command decoder, output combiner and diagnosis latch of a sixteen-channel switch.
// Contract
// - Low nibble selects channels 1-8 or 9-16.
// - Diagnosis-only ignores data, outputs unchanged.
// - Read-back returns inputs 12,11,10,9,4,3,2,1 first.
// - Then eight one-bit faults, high means OK.
// - Echo loops SI to SO next frame only.
// - Echo does no processing; afterwards zeros.
// - OR combines parallel input with serial bit.
// - AND needs both parallel and serial on.
// - Combining operation is OR after reset.
// - Combining operation latched until opposite programmed.
// - Data bit high on; first bit highest channel.
// - Undefined control bytes ignored; next response zeros.
// - Fault pin pulled low on any channel error.
// - Faults latched; newer error overwrites older report.
// - SO high impedance while chip select high.
// - Two-bit codes HH ok, HL limit, LH open, LL ground.
// - Clear read diagnosis group at chip-select fall.
// - Response is sixteen bits in next frame.
// - Chip-select rise moves received bits to outputs.
// - MSB first; sample on SCLK fall, shift on rise.
// - Reset clears shift register, switches outputs off.
// - Polarity pin high: inputs active high, else low.
`timescale 1ns/10ps
`include "sw_consts.vh"

module switch_spi_command_and_diagnosis #(
  parameter CHANNELS = 16
)
(
  // Clock and reset.
  input wire CLK,
  input wire RESETN,
  // Serial link from the host.
  input wire SCLK,
  input wire CS_N,
  input wire SI,
  output reg SO_OUT,
  output reg SO_OE_N,
  // Parallel control and polarity.
  input wire [3:0] PARALLEL_CTRL_LOW_GROUP,
  input wire [3:0] PARALLEL_CTRL_HIGH_GROUP,
  input wire INPUT_POLARITY_PIN,
  // Per-channel fault codes from the output stages, two bits per channel.
  input wire [2*CHANNELS-1:0] CHANNEL_FAULT_CODE,
  // Power output commands and general fault pin.
  output reg [CHANNELS-1:0] CHANNEL_ON,
  output reg FAULT_OUT,
  output reg FAULT_OE_N
);

  // ===================================================================
  // Functions
  // ===================================================================
  // Full diagnosis word of one group, highest channel first.
  function [15:0] diag_word;
    input [15:0] d;
    integer k;
    begin
      diag_word = 16'h0000;
      for (k = 0; k < 8; k = k + 1)
      begin
        diag_word[2*k+1 -: 2] = d[2*k+1 -: 2];
      end
    end
  endfunction

  // One-bit fault byte of one group: high means the code is normal.
  function [7:0] fault_bits;
    input [15:0] d;
    integer k;
    begin
      fault_bits = 8'h00;
      for (k = 0; k < 8; k = k + 1)
      begin
        fault_bits[k] = (d[2*k+1 -: 2] == `DIAG_NORMAL);
      end
    end
  endfunction

  // ===================================================================
  // Input synchronisers
  // ===================================================================
  reg [2:0] link_meta_reg;
  reg [2:0] link_sync_reg;
  reg [8:0] par_meta_reg;
  reg [8:0] par_sync_reg;
  reg [2*CHANNELS-1:0] code_meta_reg;
  reg [2*CHANNELS-1:0] code_sync_reg;
  reg sclk_prev_reg;
  reg cs_prev_reg;

  // Every pin passes two flops; only the second stage is read.
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      // Idle link levels: select high, clock and data low, so no false edge follows reset.
      link_meta_reg <= 3'h2;
      link_sync_reg <= 3'h2;
      par_meta_reg <= 9'h000;
      par_sync_reg <= 9'h000;
      code_meta_reg <= {2*CHANNELS{1'b1}};
      code_sync_reg <= {2*CHANNELS{1'b1}};
      sclk_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end
    else
    begin
      link_meta_reg <= {SI, CS_N, SCLK};
      link_sync_reg <= link_meta_reg;
      par_meta_reg <= {INPUT_POLARITY_PIN, PARALLEL_CTRL_HIGH_GROUP, PARALLEL_CTRL_LOW_GROUP};
      par_sync_reg <= par_meta_reg;
      code_meta_reg <= CHANNEL_FAULT_CODE;
      code_sync_reg <= code_meta_reg;
      sclk_prev_reg <= link_sync_reg[0];
      cs_prev_reg <= link_sync_reg[1];
    end
  end

  wire sclk_s = link_sync_reg[0];
  wire cs_s = link_sync_reg[1];
  wire si_s = link_sync_reg[2];
  wire cs_fall = cs_prev_reg & ~cs_s;
  wire cs_rise = ~cs_prev_reg & cs_s;
  // Clock edges only count inside a frame, so stray SCLK activity is ignored.
  wire sclk_fall = ~cs_s & sclk_prev_reg & ~sclk_s;
  wire sclk_rise = ~cs_s & ~sclk_prev_reg & sclk_s;

  // ===================================================================
  // Command state
  // ===================================================================
  reg [15:0] rx_reg;
  reg [15:0] tx_reg;
  reg [1:0] resp_kind_reg;
  reg resp_high_reg;
  reg op_and_reg;
  reg [15:0] serial_bits_reg;
  wire [2*CHANNELS-1:0] diag_bits;

  wire [3:0] func = rx_reg[`CMD_FUNC_MSB:`CMD_FUNC_LSB];
  wire [3:0] grp = rx_reg[`CMD_GRP_MSB:`CMD_GRP_LSB];
  wire grp_ok = (grp == `GRP_LOW) || (grp == `GRP_HIGH);
  wire grp_high = (grp == `GRP_HIGH);
  wire func_ok = (func == `FUNC_DIAG) || (func == `FUNC_READBACK) || (func == `FUNC_ECHO) ||
                 (func == `FUNC_OR) || (func == `FUNC_AND);
  wire cmd_valid = grp_ok & func_ok;
  wire echo_now = (resp_kind_reg == `RESP_ECHO);

  // Diagnosis of the group that the pending response reports on.
  wire [15:0] grp_diag = resp_high_reg ? diag_bits[31:16] : diag_bits[15:0];
  wire [7:0] par_pins = {par_sync_reg[7:4], par_sync_reg[3:0]};

  // Response image loaded at the falling chip-select edge.
  reg [15:0] resp_word;
  always @*
  begin
    case (resp_kind_reg)
      `RESP_DIAG: resp_word = diag_word(grp_diag);
      `RESP_READBACK: resp_word = {par_pins, fault_bits(grp_diag)};
      `RESP_ECHO: resp_word = 16'h0000;
      default: resp_word = 16'h0000;
    endcase
  end

  // ===================================================================
  // Shift registers and command decode
  // ===================================================================
  // Response and command are exchanged in separate frames: the reply of a
  // command always rides in the next chip-select period.
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rx_reg <= 16'h0000;
      tx_reg <= 16'h0000;
      resp_kind_reg <= `RESP_DIAG;
      resp_high_reg <= 1'b0;
      op_and_reg <= `RESET_OP_AND;
      serial_bits_reg <= 16'h0000;
    end
    else if (cs_fall)
    begin
      tx_reg <= {resp_word[14:0], 1'b0};
      rx_reg <= 16'h0000;
    end
    else if (cs_rise)
    begin
      if (echo_now)
      begin
        resp_kind_reg <= `RESP_ZERO;
      end
      else if (!cmd_valid)
      begin
        resp_kind_reg <= `RESP_ZERO;
      end
      else
      begin
        resp_high_reg <= grp_high;
        case (func)
          `FUNC_DIAG: resp_kind_reg <= `RESP_DIAG;
          `FUNC_READBACK: resp_kind_reg <= `RESP_READBACK;
          `FUNC_ECHO: resp_kind_reg <= `RESP_ECHO;
          `FUNC_OR:
          begin
            resp_kind_reg <= `RESP_DIAG;
            op_and_reg <= 1'b0;
          end
          default:
          begin
            resp_kind_reg <= `RESP_DIAG;
            op_and_reg <= 1'b1;
          end
        endcase
        // Data byte bit 7 commands the highest channel of the group.
        if ((func == `FUNC_OR) || (func == `FUNC_AND))
        begin
          if (grp_high)
            serial_bits_reg[15:8] <= rx_reg[7:0];
          else
            serial_bits_reg[7:0] <= rx_reg[7:0];
        end
      end
    end
    else
    begin
      if (sclk_fall)
      begin
        rx_reg <= {rx_reg[14:0], si_s};
      end
      if (sclk_rise)
      begin
        tx_reg <= {tx_reg[14:0], 1'b0};
      end
    end
  end

  // ===================================================================
  // Serial output pin
  // ===================================================================
  // In echo frames SO follows the synchronised SI, so the host sees its own
  // bits back delayed by the sampling pipeline only.
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      SO_OUT <= 1'b0;
      SO_OE_N <= 1'b1;
    end
    else
    begin
      SO_OE_N <= cs_s;
      if (cs_s)
        SO_OUT <= 1'b0;
      else if (echo_now)
        SO_OUT <= si_s;
      else if (cs_fall)
        SO_OUT <= resp_word[15];
      else if (sclk_rise)
        SO_OUT <= tx_reg[15];
    end
  end

  // ===================================================================
  // Diagnosis register
  // ===================================================================
  // A fresh error in the clearing cycle wins over the clear, so no report
  // is lost between the read and the reset of the group.
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1)
    begin : g_diag
      wire [1:0] code = code_sync_reg[2*ch+1 -: 2];
      wire in_grp = (ch >= 8) == resp_high_reg;
      wire read_now = cs_fall && in_grp &&
                      ((resp_kind_reg == `RESP_DIAG) || (resp_kind_reg == `RESP_READBACK));
      reg [1:0] slot_reg;
      always @(posedge CLK or negedge RESETN)
      begin
        if (!RESETN)
          slot_reg <= `DIAG_NORMAL;
        else if (code != `DIAG_NORMAL)
          slot_reg <= code;
        else if (read_now)
          slot_reg <= `DIAG_NORMAL;
      end
      assign diag_bits[2*ch+1 -: 2] = slot_reg;
    end
  endgenerate

  // ===================================================================
  // Output combiner and fault pin
  // ===================================================================
  // Parallel inputs are folded to active high by the polarity pin.
  wire [7:0] par_active = par_pins ^ {8{~par_sync_reg[8]}};
  reg [CHANNELS-1:0] on_next;
  integer i;
  always @*
  begin
    on_next = serial_bits_reg;
    for (i = 0; i < 4; i = i + 1)
    begin
      on_next[i] = op_and_reg ? (serial_bits_reg[i] & par_active[i]) :
                   (serial_bits_reg[i] | par_active[i]);
      on_next[i+8] = op_and_reg ? (serial_bits_reg[i+8] & par_active[i+4]) :
                     (serial_bits_reg[i+8] | par_active[i+4]);
    end
  end

  // Registered power commands and open-drain fault flag.
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      CHANNEL_ON <= {CHANNELS{1'b0}};
      FAULT_OUT <= 1'b0;
      FAULT_OE_N <= 1'b1;
    end
    else
    begin
      CHANNEL_ON <= on_next;
      FAULT_OUT <= 1'b0;
      FAULT_OE_N <= (diag_bits == {2*CHANNELS{1'b1}});
    end
  end

endmodule

// File: shared/sw_consts.vh
// Constants for the sixteen-channel switch serial command decoder.
`ifndef SW_CONSTS_VH
`define SW_CONSTS_VH

// =====================================================================
// Control byte fields
// =====================================================================
`define CMD_FUNC_MSB 15
`define CMD_FUNC_LSB 12
`define CMD_GRP_MSB 11
`define CMD_GRP_LSB 8
`define GRP_LOW 4'h0
`define GRP_HIGH 4'hF

// Function nibbles, serial order MSB first, L = 0 and H = 1.
`define FUNC_DIAG 4'h0
`define FUNC_READBACK 4'hC
`define FUNC_ECHO 4'hA
`define FUNC_OR 4'h3
`define FUNC_AND 4'hF

// =====================================================================
// Response kinds for the following chip-select cycle
// =====================================================================
`define RESP_ZERO 2'h0
`define RESP_DIAG 2'h1
`define RESP_READBACK 2'h2
`define RESP_ECHO 2'h3

// =====================================================================
// Diagnosis codes, frame length and reset values
// =====================================================================
`define DIAG_NORMAL 2'h3
`define DIAG_OVERLOAD 2'h2
`define DIAG_OPEN_LOAD 2'h1
`define DIAG_SHORT_GND 2'h0
`define FRAME_BITS 16
`define RESET_OP_AND 1'h0

`endif

// File: tb/switch_spi_command_and_diagnosis_asserts.sv
// Checker for the ports of the switch serial decoder.
`timescale 1ns/10ps
module sw_port_chk #(
  parameter CHANNELS = 16
)
(
  // Clock and reset.
  input wire CLK,
  input wire RESETN,
  // Link and pins.
  input wire CS_N,
  input wire SO_OE_N,
  input wire [2*CHANNELS-1:0] CHANNEL_FAULT_CODE,
  input wire [CHANNELS-1:0] CHANNEL_ON,
  input wire FAULT_OUT,
  input wire FAULT_OE_N
);
  // =====================================================
  // Properties
  // =====================================================
  // All checks share one clock; reset aborts every attempt.
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  property p_so_off; CS_N [*5] |-> SO_OE_N; endproperty
  a_so_off: assert property (p_so_off) else $error("SO driven while deselected");
  property p_so_on; !CS_N [*5] |-> !SO_OE_N; endproperty
  a_so_on: assert property (p_so_on) else $error("SO idle while selected");
  property p_so_start; $fell(SO_OE_N) |-> !CS_N; endproperty
  a_so_start: assert property (p_so_start) else $error("SO started outside a frame");
  property p_rst_off; $rose(RESETN) |-> CHANNEL_ON == 0; endproperty
  a_rst_off: assert property (p_rst_off) else $error("Outputs on after reset");
  // Six cycles leave room for the input synchroniser and latch.
  property p_flt_pull; (CHANNEL_FAULT_CODE != '1) [*6] |-> !FAULT_OE_N; endproperty
  a_flt_pull: assert property (p_flt_pull) else $error("Fault pin not pulled");
  property p_flt_clr; $rose(FAULT_OE_N) |-> !CS_N && CHANNEL_FAULT_CODE == '1; endproperty
  a_flt_clr: assert property (p_flt_clr) else $error("Fault released without a read");
  property p_od; !FAULT_OE_N |-> FAULT_OUT == 1'b0; endproperty
  a_od: assert property (p_od) else $error("Fault pin driven high");
  property p_ser_only; $changed(CHANNEL_ON[7:4]) || $changed(CHANNEL_ON[15:12]) |-> CS_N; endproperty
  a_ser_only: assert property (p_ser_only) else $error("Serial channel moved mid-frame");
  // Main scenarios.
  c_frame: cover property (!SO_OE_N ##1 SO_OE_N);
  c_fault: cover property ($fell(FAULT_OE_N));
  c_par: cover property ($changed(CHANNEL_ON[3:0]));
endmodule
bind switch_spi_command_and_diagnosis sw_port_chk #(.CHANNELS(CHANNELS)) u_chk (.CLK(CLK), .RESETN(RESETN),
  .CS_N(CS_N), .SO_OE_N(SO_OE_N), .CHANNEL_FAULT_CODE(CHANNEL_FAULT_CODE), .CHANNEL_ON(CHANNEL_ON),
  .FAULT_OUT(FAULT_OUT), .FAULT_OE_N(FAULT_OE_N));

// File: tb/spi_host_model.sv
// Host model that masters the serial link.
`timescale 1ns/10ps
module spi_host_model (
  // Link toward the device.
  output reg SCLK,
  output reg CS_N,
  output reg SI,
  input wire SO_OUT,
  input wire SO_OE_N
);
  integer i;
  // Idle link: clock stands low, chip select high.
  initial
  begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    SI = 1'b0;
  end
  // One frame of 16 bits at a 200 ns clock, low at both select edges.
  task xfer;
    input [15:0] tx;
    output [15:0] rx;
    begin
      #13;
      CS_N = 1'b0;
      SI = tx[15];
      #100;
      for (i = 15; i >= 0; i = i - 1)
      begin
        // SO is read just before the rising edge that moves it on.
        rx[i] = SO_OE_N ? ~SO_OUT : SO_OUT;
        SCLK = 1'b1;
        #100;
        SCLK = 1'b0;
        // The old bit stays past the device's sampling of the falling edge.
        #25;
        if (i > 0)
          SI = tx[i - 1];
        #75;
      end
      CS_N = 1'b1;
      // A stale data line must not look like valid data.
      SI = ~SI;
      #500;
    end
  endtask
endmodule

// File: tb/switch_spi_command_and_diagnosis_tb_top.sv
// Self-checking bench for the switch serial decoder.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked = samples_checked + 1; if ((g) !== (e)) begin \
  bad_count = bad_count + 1; $display("ERROR %s exp %h got %h", nm, e, g); end end
module switch_spi_command_and_diagnosis_tb_top;
  reg CLK;
  reg RESETN;
  reg [3:0] plo;
  reg [3:0] phi;
  reg pol;
  reg [31:0] fc;
  reg [15:0] rx;
  wire sclk, cs_n, si, so, so_oe_n, f_out, f_oe_n;
  wire [15:0] on;
  integer bad_count;
  integer samples_checked;
  // =====================================================
  // Design and host
  // =====================================================
  switch_spi_command_and_diagnosis #(.CHANNELS(16)) DUT (.CLK(CLK), .RESETN(RESETN), .SCLK(sclk),
    .CS_N(cs_n), .SI(si), .SO_OUT(so), .SO_OE_N(so_oe_n), .PARALLEL_CTRL_LOW_GROUP(plo),
    .PARALLEL_CTRL_HIGH_GROUP(phi), .INPUT_POLARITY_PIN(pol), .CHANNEL_FAULT_CODE(fc),
    .CHANNEL_ON(on), .FAULT_OUT(f_out), .FAULT_OE_N(f_oe_n));
  spi_host_model host (.SCLK(sclk), .CS_N(cs_n), .SI(si), .SO_OUT(so), .SO_OE_N(so_oe_n));
  // Clock at 40 MHz.
  always #12.5 CLK = ~CLK;
  // =====================================================
  // Helpers
  // =====================================================
  // Pin levels change just after an edge, then the synchronisers settle.
  task drive(input [3:0] l, input [3:0] h, input p, input [31:0] f);
    begin
      @(posedge CLK) #2;
      plo = l;
      phi = h;
      pol = p;
      fc = f;
      repeat (8) @(posedge CLK);
    end
  endtask
  task frame(input [15:0] tx);
    begin
      @(posedge CLK) #2;
      host.xfer(tx, rx);
      `CHK("so_idle", 1'b1, so_oe_n)
    end
  endtask
  // =====================================================
  // Scenarios
  // =====================================================
  task t_reset_or;
    begin
      `CHK("on_rst", 16'h0000, on)
      drive(4'hF, 4'h0, 1'b1, '1);
      `CHK("or_dflt", 16'h000F, on)
      drive(4'h0, 4'h0, 1'b1, '1);
      frame(16'h3091);
      `CHK("so_first", 16'hFFFF, rx)
      `CHK("or_ser", 16'h0091, on)
      $display("test reset_or done");
    end
  endtask
  task t_and_pol;
    begin
      drive(4'h0, 4'h5, 1'b1, '1);
      frame(16'hFF0F);
      `CHK("and_on", 16'h0590, on)
      frame(16'h00FF);
      `CHK("diag_keep", 16'h0590, on)
      drive(4'h0, 4'hF, 1'b1, '1);
      `CHK("op_latch", 16'h0F90, on)
      drive(4'h0, 4'hF, 1'b0, '1);
      `CHK("pol_low_off", 16'h0091, on)
      drive(4'h0, 4'h0, 1'b0, '1);
      `CHK("pol_low_on", 16'h0F91, on)
      $display("test and_pol done");
    end
  endtask
  task t_diag;
    begin
      drive(4'hA, 4'h3, 1'b1, '1);
      frame(16'hC000);
      drive(4'hA, 4'h3, 1'b1, 32'hFFFFFFEF);
      `CHK("flt_pin", 1'b0, f_oe_n)
      drive(4'hA, 4'h3, 1'b1, '1);
      frame(16'h0000);
      `CHK("rdback", 16'h3AFB, rx)
      drive(4'hA, 4'h3, 1'b1, 32'hFFFFFFFB);
      drive(4'hA, 4'h3, 1'b1, 32'hFFFFFFF3);
      drive(4'hA, 4'h3, 1'b1, '1);
      frame(16'h0000);
      `CHK("diag_new", 16'hFFF3, rx)
      `CHK("flt_clr", 1'b1, f_oe_n)
      $display("test diag done");
    end
  endtask
  task t_echo_bad;
    begin
      frame(16'hAF00);
      frame(16'h5A3C);
      `CHK("echo", 16'h5A3C, rx)
      `CHK("echo_on", 16'h0390, on)
      frame(16'h70F0);
      `CHK("echo_after", 16'h0000, rx)
      frame(16'h0000);
      `CHK("bad_resp", 16'h0000, rx)
      `CHK("bad_on", 16'h0390, on)
      $display("test echo_bad done");
    end
  endtask
  // Verdict and end of run.
  task final_report;
    begin
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // Main sequence.
  initial
  begin
    CLK = 1'b0;
    RESETN = 1'b0;
    plo = 4'h0;
    phi = 4'h0;
    pol = 1'b1;
    fc = '1;
    bad_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge CLK);
    #2 RESETN = 1'b1;
    repeat (6) @(posedge CLK);
    t_reset_or;
    t_and_pol;
    t_diag;
    t_echo_bad;
    final_report;
  end
  // Watchdog well beyond the roughly 41 us that the tests need.
  initial
  begin
    #300000;
    bad_count = bad_count + 1;
    final_report;
  end
endmodule
